// *** src/achs_defines.svh ***
`ifndef ACHS_DEFINES_SVH
`define ACHS_DEFINES_SVH

// clock and tick
`define ACHS_CLK_HZ          40000000
`define ACHS_TICK_CYCLES     (`ACHS_CLK_HZ)
// casing temperature thresholds, whole degrees C (unsigned 8-bit input)
`define ACHS_T_STANDBY       8'h41
`define ACHS_T_PART          8'h3C
`define ACHS_T_FULL          8'h36
`define ACHS_T_RESTART       8'h3B
// sequence times in seconds
`define ACHS_PREHEAT_S       12'h01E
`define ACHS_START_PART_S    12'h05A
`define ACHS_START_FULL_S    12'h096
`define ACHS_FAN_COOL_S      12'h078
`define ACHS_IDLE_LIMIT_S    12'h384
`define ACHS_RUN_LIMIT_S     13'h10E0
`define ACHS_COOL_PART_S     12'h064
`define ACHS_COOL_FULL_S     12'h0AF
// fuel pump pulse periods (100 / rate in Hz) and pulse width, in centiseconds
`define ACHS_CS_CYCLES       (`ACHS_CLK_HZ / 100)
`define ACHS_PER_START_CS    12'h08F
`define ACHS_PER_PART_CS     12'h04A
`define ACHS_PER_FULL_CS     12'h025
`define ACHS_PULSE_CS        12'h00A
// fan level codes
`define ACHS_FAN_OFF         2'h0
`define ACHS_FAN_SLOW        2'h1
`define ACHS_FAN_HALF        2'h2
`define ACHS_FAN_FULL        2'h3

`endif

// *** src/achs_pkg.sv ***
package achs_pkg;

    typedef enum logic [6:0] {
        ST_INACTIVE = 7'h01,
        ST_STANDBY  = 7'h02,
        ST_PREHEAT  = 7'h04,
        ST_RAMP     = 7'h08,
        ST_BURN     = 7'h10,
        ST_IDLE     = 7'h20,
        ST_COOL     = 7'h40
    } achs_state_e;

    typedef enum logic [1:0] {
        PUMP_OFF   = 2'h0,
        PUMP_START = 2'h1,
        PUMP_PART  = 2'h2,
        PUMP_FULL  = 2'h3
    } achs_pump_e;

    typedef struct packed {
        logic       circPump;
        logic       glowPlug;
        logic       flameSense;
        logic       fuelPulse;
        logic [1:0] fanLevel;
    } achs_act_s;

endpackage

// *** src/achs_sequencer.sv ***
// Overview of operation
// - circulation pump runs in standby and active modes, off when inactive.
// - on enable, start circulation pump then choose standby or active by temperature.
// - enable with casing at or above 65 C gives standby, else active.
// - standby moves to active once casing drops below 65 C.
// - start sequence begins with glow preheat and slow combustion fan.
// - fuel pump starts at start rate 30 s into the start sequence.
// - ramp raises fan to half, and pump to part rate toward full load, then switch glow to flame sensing.
// - start lasts 90 s toward part load, 150 s toward full load.
// - first entry into active mode starts toward full load.
// - full load drops to part load at casing 60 C, halving rates.
// - part load holds 55..64 C, returns to full load at 54 C.
// - casing reaching 65 C during combustion enters control idle.
// - control idle stops fuel at once, fan off after two minutes.
// - idle waits above 59 C; at 59 C within 15 min restart to part.
// - after 15 min in idle, restart toward full load instead.
// - continuous combustion over 72 minutes forces control idle.
// - after run-time cooldown, restart at once toward the needed load.
// - enable lost while active stops fuel, fan and circulation keep running.
// - shutdown cool-down lasts 100 s from part load, 175 s from full.
// - fuel pump pulsed at 0.70, 1.35 and 2.70 Hz nominal.
`timescale 1ns/100ps
`include "achs_defines.svh"
`default_nettype none

module achs_sequencer #(
    parameter int TICK_CYCLES = `ACHS_TICK_CYCLES,
    parameter int CS_CYCLES   = `ACHS_CS_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       altPowerPin,
    input  wire logic [7:0] casingTemp,
    output logic            circPump,
    output logic            glowPlug,
    output logic            flameSense,
    output logic            fuelPump,
    output logic [1:0]      fanLevel
);

    // two-stage synchronisers for the pin inputs
    logic       enMeta_q;
    logic       enSync_q;
    logic [7:0] tempMeta_q;
    logic [7:0] temp_q;
    always_ff @(posedge ref_clk) begin
        enMeta_q   <= reset ? 1'b0 : altPowerPin;
        enSync_q   <= reset ? 1'b0 : enMeta_q;
        tempMeta_q <= reset ? 8'h00 : casingTemp;
        temp_q     <= reset ? 8'h00 : tempMeta_q;
    end

    // one-second and centisecond ticks
    logic [31:0] secCnt_q;
    logic [31:0] csCnt_q;
    logic        secTick_q;
    logic        csTick_q;
    wire         secWrap = (secCnt_q == 32'(TICK_CYCLES - 1));
    wire         csWrap  = (csCnt_q == 32'(CS_CYCLES - 1));
    always_ff @(posedge ref_clk) begin
        secCnt_q  <= (reset || secWrap) ? 32'h0 : secCnt_q + 32'h1;
        secTick_q <= !reset && secWrap;
        csCnt_q   <= (reset || csWrap) ? 32'h0 : csCnt_q + 32'h1;
        csTick_q  <= !reset && csWrap;
    end

    achs_pkg::achs_state_e state_q, state_d;
    logic [11:0] seqTime_q, seqTime_d;   // seconds in current state (since preheat start in ramp)
    logic [12:0] runTime_q, runTime_d;   // continuous combustion seconds
    logic        fullTgt_q, fullTgt_d;   // start target or running load
    logic        runTrip_q, runTrip_d;   // idle entered by run-time limit
    logic        coolFull_q, coolFull_d;

    wire hotStandby = temp_q >= `ACHS_T_STANDBY;
    wire reachPart  = temp_q >= `ACHS_T_PART;
    wire fallFull   = temp_q <= `ACHS_T_FULL;
    wire fallIdle   = temp_q <= `ACHS_T_RESTART;
    wire [11:0] startLen = fullTgt_q ? `ACHS_START_FULL_S : `ACHS_START_PART_S;
    wire [11:0] secNext  = secTick_q ? seqTime_q + 12'h001 : seqTime_q;
    wire        runOver  = runTime_q > `ACHS_RUN_LIMIT_S;
    wire        coolDone = seqTime_q >= `ACHS_FAN_COOL_S;
    wire [11:0] coolLen  = coolFull_q ? `ACHS_COOL_FULL_S : `ACHS_COOL_PART_S;

    always_comb begin
        state_d    = state_q;
        seqTime_d  = secNext;
        runTime_d  = runTime_q;
        fullTgt_d  = fullTgt_q;
        runTrip_d  = runTrip_q;
        coolFull_d = coolFull_q;
        case (state_q)
            achs_pkg::ST_INACTIVE: begin
                seqTime_d = 12'h000;
                if (enSync_q) begin
                    fullTgt_d = 1'b1;
                    state_d   = hotStandby ? achs_pkg::ST_STANDBY
                                           : achs_pkg::ST_PREHEAT;
                end
            end
            achs_pkg::ST_STANDBY: begin
                seqTime_d = 12'h000;
                if (!enSync_q) begin
                    state_d = achs_pkg::ST_INACTIVE;
                end else if (!hotStandby) begin
                    fullTgt_d = 1'b1;
                    state_d   = achs_pkg::ST_PREHEAT;
                end
            end
            achs_pkg::ST_PREHEAT: begin
                if (seqTime_q >= `ACHS_PREHEAT_S) begin
                    state_d = achs_pkg::ST_RAMP;
                end
            end
            achs_pkg::ST_RAMP: begin
                if (seqTime_q >= startLen) begin
                    state_d   = achs_pkg::ST_BURN;
                    seqTime_d = 12'h000;
                    runTime_d = 13'h0000;
                end
            end
            achs_pkg::ST_BURN: begin
                runTime_d = secTick_q ? runTime_q + 13'h0001 : runTime_q;
                if (hotStandby || runOver) begin
                    state_d   = achs_pkg::ST_IDLE;
                    runTrip_d = !hotStandby;
                    seqTime_d = 12'h000;
                end else if (fullTgt_q && reachPart) begin
                    fullTgt_d = 1'b0;
                end else if (!fullTgt_q && fallFull) begin
                    fullTgt_d = 1'b1;
                end
            end
            achs_pkg::ST_IDLE: begin
                if (coolDone && runTrip_q && !hotStandby) begin
                    fullTgt_d = fallFull;
                    runTrip_d = 1'b0;
                    state_d   = achs_pkg::ST_PREHEAT;
                    seqTime_d = 12'h000;
                end else if (coolDone && fallIdle) begin
                    fullTgt_d = seqTime_q > `ACHS_IDLE_LIMIT_S;
                    runTrip_d = 1'b0;
                    state_d   = achs_pkg::ST_PREHEAT;
                    seqTime_d = 12'h000;
                end else if (seqTime_q == 12'hFFF) begin
                    seqTime_d = seqTime_q;
                end
            end
            achs_pkg::ST_COOL: begin
                if (seqTime_q >= coolLen) begin
                    state_d   = achs_pkg::ST_INACTIVE;
                    seqTime_d = 12'h000;
                end
            end
            default: begin
                state_d = achs_pkg::ST_INACTIVE;
            end
        endcase
        // enable loss while active forces the shutdown cool-down
        if (!enSync_q && state_q != achs_pkg::ST_INACTIVE &&
            state_q != achs_pkg::ST_STANDBY && state_q != achs_pkg::ST_COOL) begin
            state_d    = achs_pkg::ST_COOL;
            coolFull_d = fullTgt_q;
            seqTime_d  = 12'h000;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q    <= achs_pkg::ST_INACTIVE;
            seqTime_q  <= 12'h000;
            runTime_q  <= 13'h0000;
            fullTgt_q  <= 1'b1;
            runTrip_q  <= 1'b0;
            coolFull_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            seqTime_q  <= seqTime_d;
            runTime_q  <= runTime_d;
            fullTgt_q  <= fullTgt_d;
            runTrip_q  <= runTrip_d;
            coolFull_q <= coolFull_d;
        end
    end

    // ramp: start rate first half, then part rate toward full load, start rate toward part load
    wire rampLate = seqTime_q >= (startLen >> 1);
    achs_pkg::achs_pump_e pumpSel;
    assign pumpSel = (state_q == achs_pkg::ST_RAMP) ?
                         ((rampLate && fullTgt_q) ? achs_pkg::PUMP_PART
                                                  : achs_pkg::PUMP_START) :
                     (state_q == achs_pkg::ST_BURN) ?
                         (fullTgt_q ? achs_pkg::PUMP_FULL : achs_pkg::PUMP_PART) :
                         achs_pkg::PUMP_OFF;

    function automatic logic [11:0] pumpPeriod(input achs_pkg::achs_pump_e sel);
        case (sel)
            achs_pkg::PUMP_START: pumpPeriod = `ACHS_PER_START_CS;
            achs_pkg::PUMP_PART:  pumpPeriod = `ACHS_PER_PART_CS;
            default:              pumpPeriod = `ACHS_PER_FULL_CS;
        endcase
    endfunction

    // fuel pump pulse generator, counted in centiseconds
    logic [11:0] pumpCnt_q;
    wire         pumpOn   = pumpSel != achs_pkg::PUMP_OFF;
    wire         pumpWrap = pumpCnt_q >= pumpPeriod(pumpSel) - 12'h001;
    always_ff @(posedge ref_clk) begin
        if (reset || !pumpOn) begin
            pumpCnt_q <= 12'h000;
        end else if (csTick_q) begin
            pumpCnt_q <= pumpWrap ? 12'h000 : pumpCnt_q + 12'h001;
        end
    end

    achs_pkg::achs_act_s act_d;
    always_comb begin
        act_d.circPump   = state_q != achs_pkg::ST_INACTIVE;
        act_d.glowPlug   = state_q == achs_pkg::ST_PREHEAT ||
                           state_q == achs_pkg::ST_RAMP;
        act_d.flameSense = state_q == achs_pkg::ST_BURN;
        act_d.fuelPulse  = pumpOn && pumpCnt_q < `ACHS_PULSE_CS;
        case (state_q)
            achs_pkg::ST_PREHEAT: act_d.fanLevel = `ACHS_FAN_SLOW;
            achs_pkg::ST_RAMP:    act_d.fanLevel = rampLate ? `ACHS_FAN_HALF
                                                            : `ACHS_FAN_SLOW;
            achs_pkg::ST_BURN:    act_d.fanLevel = fullTgt_q ? `ACHS_FAN_FULL
                                                             : `ACHS_FAN_HALF;
            achs_pkg::ST_IDLE:    act_d.fanLevel = coolDone ? `ACHS_FAN_OFF
                                                            : `ACHS_FAN_HALF;
            achs_pkg::ST_COOL:    act_d.fanLevel = `ACHS_FAN_HALF;
            default:              act_d.fanLevel = `ACHS_FAN_OFF;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        circPump   <= !reset && act_d.circPump;
        glowPlug   <= !reset && act_d.glowPlug;
        flameSense <= !reset && act_d.flameSense;
        fuelPump   <= !reset && act_d.fuelPulse;
        fanLevel   <= reset ? `ACHS_FAN_OFF : act_d.fanLevel;
    end

    standby_hot_a: assert property (@(posedge ref_clk) disable iff (reset)
        state_q == achs_pkg::ST_INACTIVE && enSync_q && hotStandby
        |=> state_q == achs_pkg::ST_STANDBY)
        else $error("hot enable did not enter standby");
    circ_pump_a: assert property (@(posedge ref_clk) disable iff (reset)
        state_q != achs_pkg::ST_INACTIVE |=> circPump)
        else $error("circulation pump off while operating");
    idle_fuel_a: assert property (@(posedge ref_clk) disable iff (reset)
        state_q == achs_pkg::ST_IDLE |=> !fuelPump)
        else $error("fuel pump running in idle");
    preheat_nofuel_a: assert property (@(posedge ref_clk) disable iff (reset)
        state_q == achs_pkg::ST_PREHEAT |=> !fuelPump)
        else $error("fuel during preheat");
    cool_nofuel_a: assert property (@(posedge ref_clk) disable iff (reset)
        state_q == achs_pkg::ST_COOL |=> !fuelPump && fanLevel != `ACHS_FAN_OFF)
        else $error("cool-down outputs wrong");
    burn_hot_a: assert property (@(posedge ref_clk) disable iff (reset)
        state_q == achs_pkg::ST_BURN && hotStandby && enSync_q
        |=> state_q == achs_pkg::ST_IDLE)
        else $error("overtemperature did not enter idle");
    half_load_a: assert property (@(posedge ref_clk) disable iff (reset)
        state_q == achs_pkg::ST_BURN && fullTgt_q && reachPart && !hotStandby
        && !runOver && enSync_q |=> !fullTgt_q)
        else $error("no switch to part load");
    flame_glow_a: assert property (@(posedge ref_clk) disable iff (reset)
        !(glowPlug && flameSense))
        else $error("glow and flame sensing together");
    circ_off_a: assert property (@(posedge ref_clk) disable iff (reset)
        state_q == achs_pkg::ST_INACTIVE |=> !circPump)
        else $error("circulation pump on while inactive");
    standby_leave_a: assert property (@(posedge ref_clk) disable iff (reset)
        state_q == achs_pkg::ST_STANDBY && enSync_q && !hotStandby
        |=> state_q == achs_pkg::ST_PREHEAT && fullTgt_q)
        else $error("cooled standby did not start toward full load");
    preheat_fan_a: assert property (@(posedge ref_clk) disable iff (reset)
        state_q == achs_pkg::ST_PREHEAT |=> glowPlug && fanLevel == `ACHS_FAN_SLOW)
        else $error("preheat outputs wrong");
    preheat_len_a: assert property (@(posedge ref_clk) disable iff (reset)
        state_q == achs_pkg::ST_PREHEAT && seqTime_q < `ACHS_PREHEAT_S && enSync_q
        |=> state_q == achs_pkg::ST_PREHEAT)
        else $error("preheat ended early");
    part_fan_a: assert property (@(posedge ref_clk) disable iff (reset)
        state_q == achs_pkg::ST_BURN && !fullTgt_q |=> fanLevel == `ACHS_FAN_HALF)
        else $error("part load fan level wrong");
    full_return_a: assert property (@(posedge ref_clk) disable iff (reset)
        state_q == achs_pkg::ST_BURN && !fullTgt_q && fallFull && !hotStandby
        && !runOver && enSync_q |=> fullTgt_q)
        else $error("no return to full load");
    idle_fan_off_a: assert property (@(posedge ref_clk) disable iff (reset)
        state_q == achs_pkg::ST_IDLE && coolDone |=> fanLevel == `ACHS_FAN_OFF)
        else $error("fan still on after idle cooldown");
    idle_part_a: assert property (@(posedge ref_clk) disable iff (reset)
        state_q == achs_pkg::ST_IDLE && coolDone && fallIdle && !runTrip_q && enSync_q
        && seqTime_q <= `ACHS_IDLE_LIMIT_S
        |=> state_q == achs_pkg::ST_PREHEAT && !fullTgt_q)
        else $error("idle did not restart toward part load");
    enable_loss_a: assert property (@(posedge ref_clk) disable iff (reset)
        !enSync_q && (state_q == achs_pkg::ST_PREHEAT || state_q == achs_pkg::ST_RAMP
        || state_q == achs_pkg::ST_BURN || state_q == achs_pkg::ST_IDLE)
        |=> state_q == achs_pkg::ST_COOL)
        else $error("enable loss did not start cool-down");
    cool_end_a: assert property (@(posedge ref_clk) disable iff (reset)
        state_q == achs_pkg::ST_COOL && seqTime_q >= coolLen
        |=> state_q == achs_pkg::ST_INACTIVE)
        else $error("cool-down did not end on time");

endmodule // achs_sequencer

`default_nettype wire

// *** verification/achs_plant.sv ***
`timescale 1ns/100ps
`default_nettype none

module achs_plant (
    input  wire logic       ref_clk,
    input  wire logic [7:0] setTemp,
    input  wire logic       fuelPump,
    output logic [7:0]      casingTemp,
    output int              fuelPeriod,
    output int              fuelRises
);
    int   sinceRise = 0;
    logic fuelPrev  = 1'b0;

    // sensor reading is held steady between the bench's changes
    assign casingTemp = setTemp;

    // measures the fuel pulse period in clock cycles, rising edge to rising edge
    always @(posedge ref_clk) begin
        fuelPrev  <= fuelPump;
        sinceRise <= (fuelPump && !fuelPrev) ? 1 : sinceRise + 1;
        if (fuelPump && !fuelPrev) begin
            fuelPeriod <= sinceRise;
            fuelRises  <= fuelRises + 1;
        end
    end
endmodule // achs_plant

`default_nettype wire

// *** verification/aux_coolant_heater_sequencer_bench.sv ***
`timescale 1ns/100ps
`default_nettype none

module aux_coolant_heater_sequencer_bench;
    localparam int TICK = 100;
    localparam int CS   = 1;

    logic       ref_clk     = 1'b0;
    logic       reset       = 1'b1;
    logic       altPowerPin = 1'b0;
    logic [7:0] setTemp     = 8'h14;
    logic [7:0] casingTemp;
    logic       circPump;
    logic       glowPlug;
    logic       flameSense;
    logic       fuelPump;
    logic [1:0] fanLevel;
    int         fuelPeriod;
    int         fuelRises;
    int         rises0;
    int         bad_count   = 0;
    int         cmp_count   = 0;
    int         cycles      = 0;

    always #12.5 ref_clk = ~ref_clk;

    achs_sequencer #(.TICK_CYCLES(TICK), .CS_CYCLES(CS)) dut (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .altPowerPin(altPowerPin),
        .casingTemp (casingTemp),
        .circPump   (circPump),
        .glowPlug   (glowPlug),
        .flameSense (flameSense),
        .fuelPump   (fuelPump),
        .fanLevel   (fanLevel)
    );

    achs_plant plant (
        .ref_clk   (ref_clk),
        .setTemp   (setTemp),
        .fuelPump  (fuelPump),
        .casingTemp(casingTemp),
        .fuelPeriod(fuelPeriod),
        .fuelRises (fuelRises)
    );

    task automatic final_report;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask

    task automatic secs(input int n);
        cyc(n * TICK);
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic chk_int(input string name, input int exp, input int got);
        cmp_count++;
        if (got != exp) begin
            bad_count++;
            $display("unexpected %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    // compares the level outputs; the fuel pulse is judged separately
    task automatic chk_act(input string name, input int c, input int g, input int f,
                           input logic [1:0] fan);
        achs_pkg::achs_act_s exp;
        achs_pkg::achs_act_s seen;
        exp  = '{circPump: 1'(c), glowPlug: 1'(g), flameSense: 1'(f),
                 fuelPulse: 1'b0, fanLevel: fan};
        seen = '{circPump: circPump, glowPlug: glowPlug, flameSense: flameSense,
                 fuelPulse: 1'b0, fanLevel: fanLevel};
        chk(name, 8'(exp), 8'(seen));
    endtask

    task automatic t_standby;
        chk_act("outputs in reset", 0, 0, 0, 2'h0);
        reset       = 1'b0;
        setTemp     = 8'h41;
        altPowerPin = 1'b1;
        cyc(6);
        chk_act("standby outputs", 1, 0, 0, 2'h0);
        secs(3);
        chk_act("standby held", 1, 0, 0, 2'h0);
        setTemp = 8'h40;
        cyc(6);
        chk_act("preheat outputs", 1, 1, 0, 2'h1);
    endtask

    task automatic t_start_full;
        // below the part-load threshold so that the start ends at full load
        setTemp = 8'h30;
        secs(28);
        chk_int("fuel rises in preheat", 0, fuelRises);
        secs(12);
        chk_int("start fuel period", 143 * CS, fuelPeriod);
        chk_act("ramp outputs", 1, 1, 0, 2'h1);
        secs(60);
        chk_int("ramp fuel period", 74 * CS, fuelPeriod);
        secs(48);
        chk_act("ramp before 150 s", 1, 1, 0, 2'h2);
        secs(4);
        chk_act("full load outputs", 1, 0, 1, 2'h3);
        secs(3);
        chk_int("full fuel period", 37 * CS, fuelPeriod);
    endtask

    task automatic t_regulate;
        setTemp = 8'h3C;
        cyc(6);
        chk("fan at 60 C", 8'h02, 8'(fanLevel));
        secs(3);
        chk_int("part fuel period", 74 * CS, fuelPeriod);
        setTemp = 8'h37;
        secs(2);
        chk("fan at 55 C", 8'h02, 8'(fanLevel));
        setTemp = 8'h36;
        cyc(6);
        chk("fan at 54 C", 8'h03, 8'(fanLevel));
        setTemp = 8'h41;
        cyc(6);
        rises0 = fuelRises;
        chk("fuel in idle", 8'h00, 8'(fuelPump));
        chk("fan in idle", 8'h02, 8'(fanLevel));
        secs(117);
        chk("fan before 120 s", 8'h02, 8'(fanLevel));
        setTemp = 8'h3C;
        secs(4);
        chk_act("idle after cooldown", 1, 0, 0, 2'h0);
        chk_int("fuel rises in idle", rises0, fuelRises);
        setTemp = 8'h3B;
        secs(2);
        chk_act("restart preheat", 1, 1, 0, 2'h1);
        secs(87);
        chk("flame before 90 s", 8'h00, 8'(flameSense));
        secs(4);
        chk_act("part load outputs", 1, 0, 1, 2'h2);
    endtask

    task automatic t_shutdown;
        altPowerPin = 1'b0;
        cyc(6);
        rises0 = fuelRises;
        chk("fuel at shutdown", 8'h00, 8'(fuelPump));
        chk("fan at shutdown", 8'h02, 8'(fanLevel));
        chk("circ at shutdown", 8'h01, 8'(circPump));
        secs(98);
        chk("circ before 100 s", 8'h01, 8'(circPump));
        chk_int("fuel rises in cool-down", rises0, fuelRises);
        secs(4);
        chk_act("inactive after cool-down", 0, 0, 0, 2'h0);
    endtask

    // cuts a hang short well past the expected run of about 50000 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 70000) begin
            bad_count++;
            final_report();
        end
    end

    initial begin
        cyc(3);
        t_standby();
        // a second reset in mid-run must bring everything back to the inactive state
        reset       = 1'b1;
        altPowerPin = 1'b0;
        cyc(3);
        t_standby();
        t_start_full();
        t_regulate();
        t_shutdown();
        final_report();
    end
endmodule // aux_coolant_heater_sequencer_bench

`default_nettype wire
